//--- design/pb_vlan_params.svh
`ifndef PB_VLAN_PARAMS_SVH
`define PB_VLAN_PARAMS_SVH

// ----------------------------------------------------------------------
// Tag identifiers and length allowances
// ----------------------------------------------------------------------
`define PB_TPID_CUSTOMER   16'h8100
`define PB_TPID_SERVICE    16'h88A8
`define PB_ONE_TAG_BYTES   17'h00004
`define PB_TWO_TAG_BYTES   17'h00008
`define PB_NO_TAG_BYTES    17'h00000
`define PB_MAXLEN_RESET    16'h05EE
`define PB_VID_PRIORITY    12'h000

// ----------------------------------------------------------------------
// Register offsets (global block, then per-port block)
// ----------------------------------------------------------------------
`define PB_OFS_INDEX       12'h000
`define PB_OFS_COMMAND     12'h004
`define PB_OFS_STATUS      12'h008
`define PB_OFS_ENTRY       12'h00C
`define PB_PORT_REGION     4'h1
`define PB_PREG_CONFIG     2'h0
`define PB_PREG_MAXLEN     2'h1
`define PB_PREG_TPID       2'h2
`define PB_PREG_EGRESS_VID 2'h3

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PB_CFG_RECOGNISE   0
`define PB_CFG_LEN_AWARE   1
`define PB_CFG_DOUBLE_LEN  2
`define PB_CFG_CLASSIFY    3
`define PB_CFG_STRIP       4
`define PB_CFG_PUSH_KIND   5
`define PB_CFG_INNER       6
`define PB_CFG_D_UNTAG     8
`define PB_CFG_D_CUST      9
`define PB_CFG_D_PCUST     10
`define PB_CFG_D_SVC       11
`define PB_CFG_D_PSVC      12
`define PB_CFG_EG_LO       16
`define PB_CFG_VID_LO      20
`define PB_CONFIG_RESET    32'h0000_0000
`define PB_IDX_FLAGS_LO    16
`define PB_CMD_BUSY_BIT    31

// ----------------------------------------------------------------------
// Table commands and egress tagging modes
// ----------------------------------------------------------------------
`define PB_CMD_IDLE        2'h0
`define PB_CMD_READ        2'h1
`define PB_CMD_WRITE       2'h2
`define PB_EG_NONE         2'h0
`define PB_EG_SKIP_PORT_DEFAULT_VID_VALUE    2'h1
`define PB_EG_SKIP_PRIO    2'h2
`define PB_EG_ALL          2'h3

`endif

//--- design/pb_vlan_pkg.sv
package pb_vlan_pkg;
   // Table sweep after reset, then normal running.
   typedef enum logic {tbl_init, tbl_run} table_state_t;
endpackage

//--- design/provider_bridge_vlan_tagging.sv
`timescale 1ns/1ps
`include "pb_vlan_params.svh"

// ----------------------------------------------------------------------
// Descriptor FIFO
// ----------------------------------------------------------------------
// DEPTH must be a power of two; the extra pointer bit tells full from empty.
module pb_desc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output wire logic             in_ready,
   // Draining side
   output wire logic             out_valid,
   output wire logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];

   // Storage carries no reset; only the pointers define what is valid.
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointers move only on a completed handshake.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// Functional notes
// - Outer or inner tag with type 8100 hex is a customer tag.
// - Type 88A8 hex or the port's programmable type marks a service tag.
// - One tag adds 4 bytes allowance; two tags add 8 in double mode.
// - Length is checked against a per-port maximum excluding tags, 1518 typical.
// - Per-port discard of untagged, service and priority service tagged frames.
// - Per-port discard of customer and priority customer tagged frames.
// - Tag-aware ports classify from tags; others always use the port VID.
// - Rewriter strips at most one leading tag as the port's strip bit says.
// - Push tag kind chooses customer or, when one, service tag 88A8 hex.
// - Inner-tag setting classifies double-tagged frames by the inner tag.
// - A table flag turns learning off per VLAN; such frames are flooded.
// - 4096 entries set through index then command; mask plus four flags.
// - Egress mode zero sends frames without inserting any tag.
// - An outer tag carrying the classified VID can be pushed on egress.
// - Command value two writes the indexed entry with mask and flags.
// - Egress modes: 3 tag all, 0 none, 1 skip port VID, 2 also priority.
module provider_bridge_vlan_tagging #(
   parameter int NPORTS      = 4,
   parameter int VLAN_COUNT  = 4096,
   parameter int FIFO_DEPTH  = 8
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB register port
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Received frame header descriptor
   input  wire logic              rx_valid,
   output logic                   rx_ready,
   input  wire logic [1:0]        rx_port,
   input  wire logic [1:0]        rx_egress_port,
   input  wire logic [15:0]       rx_length,
   input  wire logic [15:0]       rx_tpid_outer,
   input  wire logic [15:0]       rx_tci_outer,
   input  wire logic [15:0]       rx_tpid_inner,
   input  wire logic [15:0]       rx_tci_inner,
   // Forwarding and rewrite decision
   output logic                   tx_valid,
   input  wire logic              tx_ready,
   output logic                   tx_discard,
   output logic      [11:0]       tx_vid,
   output logic      [NPORTS-1:0] tx_member_mask,
   output logic                   tx_learn,
   output logic                   tx_flood,
   output logic                   tx_strip,
   output logic                   tx_push,
   output logic      [15:0]       tx_push_tpid
);
   localparam int EW = NPORTS + 4;
   localparam int DW = NPORTS + 33;
   localparam int CW = $clog2(VLAN_COUNT);

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   logic [31:0]   port_config  [NPORTS];
   logic [15:0]   port_maxlen  [NPORTS];
   logic [15:0]   port_tpid    [NPORTS];
   logic [11:0]   port_eg_vid  [NPORTS];
   logic [11:0]   vlan_table_index;
   logic [3:0]    index_flags;
   logic [EW-1:0] vlan_table [VLAN_COUNT];
   logic [EW-1:0] entry_readback;
   logic [15:0]   forwarded_count;
   logic [15:0]   discarded_count;
   logic [CW-1:0] init_idx;
   pb_vlan_pkg::table_state_t state;

   logic        apb_write;
   logic        apb_setup;
   logic        port_hit;
   logic [1:0]  ap;
   logic [31:0] next_prdata;
   logic        next_slverr;

   assign apb_write = psel && penable && pready && pwrite;
   assign apb_setup = psel && !penable;
   assign ap        = paddr[5:4];
   assign port_hit  = (paddr[11:8] == `PB_PORT_REGION) && (int'(paddr[7:4]) < NPORTS);

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   // Read data and error are chosen while the setup cycle stands.
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      if (port_hit) begin
         unique case (paddr[3:2])
            `PB_PREG_CONFIG:     next_prdata = port_config[ap];
            `PB_PREG_MAXLEN:     next_prdata = {16'h0000, port_maxlen[ap]};
            `PB_PREG_TPID:       next_prdata = {16'h0000, port_tpid[ap]};
            `PB_PREG_EGRESS_VID: next_prdata = {20'h00000, port_eg_vid[ap]};
         endcase
      end else if (paddr == `PB_OFS_INDEX) begin
         next_prdata = {12'h000, index_flags, 4'h0, vlan_table_index};
      end else if (paddr == `PB_OFS_COMMAND) begin
         next_prdata[`PB_CMD_BUSY_BIT] = (state == pb_vlan_pkg::tbl_init);
      end else if (paddr == `PB_OFS_STATUS) begin
         next_prdata = {discarded_count, forwarded_count};
      end else if (paddr == `PB_OFS_ENTRY) begin
         next_prdata = {{(32-EW){1'b0}}, entry_readback};
      end else begin
         next_slverr = 1'b1;
      end
   end

   // No wait state: ready rises in the first access cycle and drops after.
   // The error flag stands only beside ready, so a stale error never leaks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup && next_slverr;
         if (apb_setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
         end
      end
   end

   // Per-port configuration, one copy for each port.
   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            port_config[p] <= `PB_CONFIG_RESET;
            port_maxlen[p] <= `PB_MAXLEN_RESET;
            port_tpid[p]   <= `PB_TPID_SERVICE;
            port_eg_vid[p] <= `PB_VID_PRIORITY;
         end else if (apb_write && port_hit && (int'(ap) == p)) begin
            unique case (paddr[3:2])
               `PB_PREG_CONFIG:     port_config[p] <= pwdata;
               `PB_PREG_MAXLEN:     port_maxlen[p] <= pwdata[15:0];
               `PB_PREG_TPID:       port_tpid[p]   <= pwdata[15:0];
               `PB_PREG_EGRESS_VID: port_eg_vid[p] <= pwdata[11:0];
            endcase
         end
      end
   end

   // Index register: entry number and the four flags of the next insert.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vlan_table_index <= 12'h000;
         index_flags      <= 4'h0;
      end else if (apb_write && (paddr == `PB_OFS_INDEX)) begin
         vlan_table_index <= pwdata[11:0];
         index_flags      <= pwdata[`PB_IDX_FLAGS_LO +: 4];
      end
   end

   // ----------------------------------------------------------------------
   // VLAN table
   // ----------------------------------------------------------------------
   logic tbl_write;
   logic tbl_read;

   // Commands are refused while the reset sweep still owns the table.
   assign tbl_write = apb_write && (paddr == `PB_OFS_COMMAND) && (state == pb_vlan_pkg::tbl_run)
                      && (pwdata[1:0] == `PB_CMD_WRITE);
   assign tbl_read  = apb_write && (paddr == `PB_OFS_COMMAND) && (state == pb_vlan_pkg::tbl_run)
                      && (pwdata[1:0] == `PB_CMD_READ);

   // After reset every VLAN holds every port, with all flags cleared.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= pb_vlan_pkg::tbl_init;
         init_idx <= '0;
      end else begin
         unique case (state)
            pb_vlan_pkg::tbl_init: begin
               init_idx <= init_idx + 1'b1;
               if (int'(init_idx) == VLAN_COUNT - 1) begin
                  state <= pb_vlan_pkg::tbl_run;
               end
            end
            pb_vlan_pkg::tbl_run: state <= pb_vlan_pkg::tbl_run;
         endcase
      end
   end

   // Entry layout: source check, learn off, flag a, private, member mask.
   always_ff @(posedge pclk) begin
      if (state == pb_vlan_pkg::tbl_init) begin
         vlan_table[init_idx] <= {4'h0, {NPORTS{1'b1}}};
      end else if (tbl_write) begin
         vlan_table[vlan_table_index[CW-1:0]] <= {index_flags, pwdata[2 +: NPORTS]};
      end
   end

   // A read command copies the indexed entry where software can see it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         entry_readback <= '0;
      end else if (tbl_read) begin
         entry_readback <= vlan_table[vlan_table_index[CW-1:0]];
      end
   end

   // ----------------------------------------------------------------------
   // Ingress classification
   // ----------------------------------------------------------------------
   logic [31:0] cfg;
   logic        outer_cust;
   logic        outer_svc;
   logic        outer_tagged;
   logic        inner_tagged;
   logic        double_tagged;
   logic        outer_prio;
   logic [11:0] sel_vid;
   logic [11:0] class_vid;
   logic [16:0] allowance;
   logic        too_long;
   logic        discard;
   logic        push;

   assign cfg = port_config[rx_port];

   // Unknown tag types fall through as untagged frames.
   assign outer_cust   = (rx_tpid_outer == `PB_TPID_CUSTOMER);
   assign outer_svc    = (rx_tpid_outer == `PB_TPID_SERVICE)
                         || (rx_tpid_outer == port_tpid[rx_port]);
   assign outer_tagged = outer_cust || outer_svc;
   assign inner_tagged = (rx_tpid_inner == `PB_TPID_CUSTOMER) || (rx_tpid_inner == `PB_TPID_SERVICE)
                         || (rx_tpid_inner == port_tpid[rx_port]);
   assign double_tagged = outer_tagged && inner_tagged;
   assign outer_prio    = (rx_tci_outer[11:0] == `PB_VID_PRIORITY);

   // Tag allowance sits on top of a maximum that never counts tags.
   always_comb begin
      allowance = `PB_NO_TAG_BYTES;
      if (cfg[`PB_CFG_RECOGNISE] && cfg[`PB_CFG_LEN_AWARE] && outer_tagged) begin
         allowance = (cfg[`PB_CFG_DOUBLE_LEN] && double_tagged) ?
                     `PB_TWO_TAG_BYTES : `PB_ONE_TAG_BYTES;
      end
   end
   assign too_long = {1'b0, rx_length} > ({1'b0, port_maxlen[rx_port]} + allowance);

   // Acceptable frame types per port.
   always_comb begin
      discard = too_long;
      if (!outer_tagged && cfg[`PB_CFG_D_UNTAG]) begin
         discard = 1'b1;
      end
      if (outer_svc && (outer_prio ? cfg[`PB_CFG_D_PSVC] : cfg[`PB_CFG_D_SVC])) begin
         discard = 1'b1;
      end
      if (outer_cust && !outer_svc && (outer_prio ? cfg[`PB_CFG_D_PCUST] : cfg[`PB_CFG_D_CUST])) begin
         discard = 1'b1;
      end
   end

   // Priority tags and tag-unaware ports fall back to the port VID.
   assign sel_vid   = (cfg[`PB_CFG_INNER] && double_tagged) ?
                      rx_tci_inner[11:0] : rx_tci_outer[11:0];
   assign class_vid = (cfg[`PB_CFG_CLASSIFY] && outer_tagged && (sel_vid != `PB_VID_PRIORITY)) ?
                      sel_vid : cfg[`PB_CFG_VID_LO +: 12];

   // Egress tagging for the port the frame leaves by.
   always_comb begin
      unique case (port_config[rx_egress_port][`PB_CFG_EG_LO +: 2])
         `PB_EG_NONE:      push = 1'b0;
         `PB_EG_SKIP_PORT_DEFAULT_VID_VALUE: push = (class_vid != port_eg_vid[rx_egress_port]);
         `PB_EG_SKIP_PRIO: push = (class_vid != port_eg_vid[rx_egress_port])
                                  && !(outer_tagged && outer_prio);
         `PB_EG_ALL:       push = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------------
   // Pipeline stage, table lookup and FIFO
   // ----------------------------------------------------------------------
   logic          s1_valid;
   logic          s1_discard;
   logic [11:0]   s1_vid;
   logic          s1_strip;
   logic          s1_push;
   logic [15:0]   s1_tpid;
   logic          next_s1_valid;
   logic [EW-1:0] s1_entry;
   logic          f_in_ready;
   logic          f_out_valid;
   logic [DW-1:0] f_in_data;
   logic [DW-1:0] f_out_data;
   logic          f_pop;

   assign next_s1_valid = (s1_valid && !f_in_ready) || (rx_valid && rx_ready);
   assign s1_entry      = vlan_table[s1_vid[CW-1:0]];
   // Learning off in the entry means no learning and flooding to members.
   assign f_in_data = {s1_discard, s1_vid, s1_entry[NPORTS-1:0],
                       !s1_entry[NPORTS+2], s1_entry[NPORTS+2],
                       s1_strip, s1_push, s1_tpid};

   // The header stage holds until the FIFO takes it, which stalls intake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_valid   <= 1'b0;
         s1_discard <= 1'b0;
         s1_vid     <= `PB_VID_PRIORITY;
         s1_strip   <= 1'b0;
         s1_push    <= 1'b0;
         s1_tpid    <= `PB_TPID_CUSTOMER;
         rx_ready   <= 1'b0;
      end else begin
         s1_valid <= next_s1_valid;
         rx_ready <= !next_s1_valid && (state == pb_vlan_pkg::tbl_run);
         if (rx_valid && rx_ready) begin
            s1_discard <= discard;
            s1_vid     <= class_vid;
            s1_strip   <= cfg[`PB_CFG_STRIP] && outer_tagged;
            s1_push    <= push;
            s1_tpid    <= cfg[`PB_CFG_PUSH_KIND] ? `PB_TPID_SERVICE : `PB_TPID_CUSTOMER;
         end
      end
   end

   // Forwarded and discarded frames are counted as they enter the FIFO.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         forwarded_count <= 16'h0000;
         discarded_count <= 16'h0000;
      end else if (s1_valid && f_in_ready) begin
         if (s1_discard) begin
            discarded_count <= discarded_count + 16'h0001;
         end else begin
            forwarded_count <= forwarded_count + 16'h0001;
         end
      end
   end

   pb_desc_fifo #(
      .WIDTH (DW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (s1_valid),
      .in_data   (f_in_data),
      .in_ready  (f_in_ready),
      .out_valid (f_out_valid),
      .out_data  (f_out_data),
      .out_ready (f_pop)
   );

   // Output register keeps every decision port on a flip-flop.
   assign f_pop = f_out_valid && (!tx_valid || tx_ready);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_valid       <= 1'b0;
         tx_discard     <= 1'b0;
         tx_vid         <= `PB_VID_PRIORITY;
         tx_member_mask <= '0;
         tx_learn       <= 1'b0;
         tx_flood       <= 1'b0;
         tx_strip       <= 1'b0;
         tx_push        <= 1'b0;
         tx_push_tpid   <= `PB_TPID_CUSTOMER;
      end else if (!tx_valid || tx_ready) begin
         tx_valid <= f_out_valid;
         if (f_out_valid) begin
            {tx_discard, tx_vid, tx_member_mask, tx_learn, tx_flood,
             tx_strip, tx_push, tx_push_tpid} <= f_out_data;
         end
      end
   end
endmodule

//--- tb/pb_vlan_checker.sv
`timescale 1ns/1ps
// Protocol watch on the top-level ports of the VLAN tagging block.
module pb_vlan_checker (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Register port
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   // Frame path
   input wire logic        rx_valid,
   input wire logic        rx_ready,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic        tx_discard,
   input wire logic [11:0] tx_vid,
   input wire logic        tx_learn,
   input wire logic        tx_flood,
   input wire logic [15:0] tx_push_tpid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Setup phase of a register transfer, and a descriptor handover.
   sequence s_setup; psel && !penable; endsequence
   sequence s_take; rx_valid && rx_ready; endsequence
   a_apb_answer: assert property (s_setup |=> pready)
      else $error("register access not answered in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
      else $error("error flag outside an access phase");
   a_rx_gap: assert property (s_take |=> !rx_ready)
      else $error("descriptor accepted on consecutive cycles");
   a_tx_answer: assert property (s_take |-> ##[3:60] tx_valid)
      else $error("no decision after a descriptor was taken");
   a_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_vid) && $stable(tx_discard))
      else $error("decision changed while stalled");
   a_flood_learn: assert property (tx_valid |-> tx_flood != tx_learn)
      else $error("flooding does not mirror learning");
   a_push_kind: assert property (tx_valid |->
      tx_push_tpid == 16'h8100 || tx_push_tpid == 16'h88A8)
      else $error("pushed tag type is neither customer nor service");
endmodule

bind provider_bridge_vlan_tagging pb_vlan_checker i_pb_vlan_checker (.pclk, .presetn,
   .psel, .penable, .pready, .pslverr, .rx_valid, .rx_ready, .tx_valid, .tx_ready,
   .tx_discard, .tx_vid, .tx_learn, .tx_flood, .tx_push_tpid);

//--- tb/pb_frame_port.sv
`timescale 1ns/1ps
// Far side: offers received frame headers and takes the decisions.
module pb_frame_port (
   // Clock and pacing
   input  wire logic        pclk,
   input  wire logic        accept,
   // Header offer
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic [1:0]       rx_port,
   output logic [1:0]       rx_egress_port,
   output logic [15:0]      rx_length,
   output logic [15:0]      rx_tpid_outer,
   output logic [15:0]      rx_tci_outer,
   output logic [15:0]      rx_tpid_inner,
   output logic [15:0]      rx_tci_inner,
   // Decision sink
   output logic             tx_ready
);
   initial begin
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // The sink stalls at random, as a congested egress queue would.
   always @(posedge pclk) tx_ready <= accept;
   // Hold one header until taken; released fields turn inverted so stale
   // values never look plausible. Every frame leaves by egress port 2.
   task automatic send(input logic [1:0] p, input logic [15:0] len, to, co, ti, ci);
      logic [83:0] h;
      h = {p, 2'h2, len, to, co, ti, ci};
      @(posedge pclk);
      rx_valid <= 1'b1;
      {rx_port, rx_egress_port, rx_length, rx_tpid_outer, rx_tci_outer,
       rx_tpid_inner, rx_tci_inner} <= h;
      do @(posedge pclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      {rx_port, rx_egress_port, rx_length, rx_tpid_outer, rx_tci_outer,
       rx_tpid_inner, rx_tci_inner} <= ~h;
   endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {logic d; logic [11:0] v; logic [3:0] m;
                          logic l; logic [1:0] s; logic [15:0] t;} exp_t;
   localparam exp_t drop = '{1'b1, 12'h000, 4'h0, 1'b0, 2'b00, 16'h0000};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, accept = 1'b0, e;
   logic [11:0] paddr = 12'h000, tx_vid;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, rs, seed = 32'hB987CFFC;
   logic [15:0] rx_length, rx_tpid_outer, rx_tci_outer, rx_tpid_inner, rx_tci_inner;
   logic [15:0] tx_push_tpid, rv;
   logic [1:0]  rx_port, rx_egress_port;
   logic [3:0]  tx_member_mask;
   logic        pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, tx_discard;
   logic        tx_learn, tx_flood, tx_strip, tx_push;
   int          n_mismatch = 0, n_compared = 0;
   exp_t        q[$], x;

   // A short table keeps the post-reset sweep brief.
   provider_bridge_vlan_tagging #(.VLAN_COUNT(16)) i_provider_bridge_vlan_tagging (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_valid, .rx_ready, .rx_port, .rx_egress_port, .rx_length,
      .rx_tpid_outer, .rx_tci_outer, .rx_tpid_inner, .rx_tci_inner, .tx_valid,
      .tx_ready, .tx_discard, .tx_vid, .tx_member_mask, .tx_learn, .tx_flood,
      .tx_strip, .tx_push, .tx_push_tpid);
   pb_frame_port i_frame_port (.pclk, .accept, .rx_valid, .rx_ready, .rx_port,
      .rx_egress_port, .rx_length, .rx_tpid_outer, .rx_tci_outer, .rx_tpid_inner,
      .rx_tci_inner, .tx_ready);

   always #5 pclk = ~pclk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Random back-pressure, ready three cycles in four.
   always @(posedge pclk) begin
      rs = xs();
      accept <= rs[0] | rs[1];
   end
   task automatic chk(input logic [39:0] got, want);
      n_compared++;
      if (got !== want) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // One transfer: setup, then access until ready, then release.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] want, input logic err);
      apb(1'b0, a, 32'h0000_0000);
      chk({e, rd}, {err, want});
   endtask
   task automatic fr(input logic [1:0] p, input logic [15:0] len, to, co, ti, ci,
                     input exp_t w);
      q.push_back(w);
      i_frame_port.send(p, len, to, co, ti, ci);
   endtask
   // Decisions come out in order; compare each against the oldest note.
   always @(posedge pclk) if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      x = (q.size() != 0) ? q.pop_front() : ~drop;
      chk(tx_discard, x.d);
      if (x.d !== 1'b1) chk({tx_vid, tx_member_mask, tx_learn, tx_strip, tx_push,
         tx_push_tpid}, {x.v, x.m, x.l, x.s, x.t});
   end
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #50000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h104, 32'h0000_05EE, 1'b0);
      rdc(12'h108, 32'h0000_88A8, 1'b0);
      rdc(12'h100, 32'h0000_0000, 1'b0);
      rdc(12'h800, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h100, 32'h0010_0423);
      apb(1'b1, 12'h110, 32'h0030_011F);
      for (int i = 0; i < 200 && rx_ready !== 1'b1; i++) @(posedge pclk);
      apb(1'b1, 12'h000, 32'h0004_0001);
      apb(1'b1, 12'h004, 32'h0000_000E);
      rdc(12'h000, 32'h0004_0001, 1'b0);
      apb(1'b1, 12'h004, 32'h0000_0001);
      rdc(12'h00C, 32'h0000_0043, 1'b0);
      rv = xs();
      fr(0, 1522, 16'h8100, {rv[15:12], 12'h005}, 16'h0800, rv,
         '{1'b0, 12'h001, 4'h3, 1'b0, 2'b00, 16'h88A8});
      fr(0, 1523, 16'h8100, {rv[11:8], 12'h005}, 16'h0800, rv, drop);
      fr(0, 1518, 16'h8100, {rv[7:4], 12'h000}, 16'h0800, rv, drop);
      fr(1, 1526, 16'h88A8, {rv[3:0], 12'h002}, 16'h8100, 16'h0007,
         '{1'b0, 12'h002, 4'hF, 1'b1, 2'b10, 16'h8100});
      fr(1, 100, 16'h0800, rv, 16'h0800, rv, drop);
      fr(1, 100, 16'h1234, 16'h0009, 16'h0800, rv, drop);
      apb(1'b1, 12'h118, 32'h0000_9100);
      fr(1, 1526, 16'h9100, 16'h0004, 16'h8100, 16'h0007,
         '{1'b0, 12'h004, 4'hF, 1'b1, 2'b10, 16'h8100});
      apb(1'b1, 12'h110, 32'h0030_015F);
      fr(1, 1526, 16'h88A8, 16'h0002, 16'h8100, 16'h0007,
         '{1'b0, 12'h007, 4'hF, 1'b1, 2'b10, 16'h8100});
      apb(1'b1, 12'h120, 32'h0003_0000);
      fr(1, 1526, 16'h88A8, 16'h0002, 16'h8100, 16'h0007,
         '{1'b0, 12'h007, 4'hF, 1'b1, 2'b11, 16'h8100});
      apb(1'b1, 12'h12C, 32'h0000_0007);
      apb(1'b1, 12'h120, 32'h0001_0000);
      fr(1, 1526, 16'h88A8, 16'h0002, 16'h8100, 16'h0007,
         '{1'b0, 12'h007, 4'hF, 1'b1, 2'b10, 16'h8100});
      for (int i = 0; i < 300 && q.size() != 0; i++) @(posedge pclk);
      if (q.size() != 0) n_mismatch++;
      end_sim();
   end
endmodule
